/* src/ncw_node_regs.sv */
// module: node configuration, link control/status and watchdog registers
//
// Functional notes
// - 7-bit MHz field, resets to 25
// - only 5..100 accepted, else NACK, unchanged
// - software rewrites frequency after start and change
// - frequency drives reset delay, tick, sleep clock
// - error bit 27 sets on overflow/bad token
// - bit 26 shows credit issued to remote
// - bit 25 shows own transmit credit held
// - bit 24 starts init, sends greeting, self-clears
// - remote answers greeting with credits
// - bit 23 resets receiver, self-clears
// - bits 21:11 transition spacing, reset 1
// - bits 10:0 token spacing, reset 1
// - 16-bit timeout in 1 ms ticks, reset 1000
// - watchdog counts only in active power state
// - timeout write needs complement, ACK else NACK
// - application kicks watchdog before expiry
// - expiry resets processor tile
// - upper half reads current count, reset 0
// - disable key resets/stops, zero enables
// - lock bit freezes node and link registers
`default_nettype none
module ncw_node_regs (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              nrst,
  // configuration access
  input  wire logic              cfg_wr,
  input  wire logic              cfg_rd,
  input  wire logic [7:0]        cfg_addr,
  input  wire logic [31:0]       cfg_wdata,
  output logic [31:0]            cfg_rdata_q,
  output ncw_pkg::ncw_ans_t      cfg_ans_q,
  // power and kick
  input  wire logic              active_power_state,
  input  wire logic              wd_kick,
  // link
  ncw_link_if.dev                link,
  // derived controls
  output logic                   tile_reset_q,
  output logic                   rx_resync_q,
  output logic                   sleep_tick_q
);
  logic [6:0]  freq_q;
  logic        lock_q, hdr_q;
  logic        err_q, issued_q, have_q;
  logic [10:0] trans_gap_q, tok_gap_q;
  logic [15:0] wd_to_q, wd_cnt_q;
  logic        wd_en_q, wd_restart;
  logic [31:0] wd_dis_q;
  logic [16:0] tick_div_q;
  logic        tick_q;
  logic [11:0] rst_dly_q;
  logic        init_req_q, tok_busy, trans_busy, tok_start;
  logic        wr_node, wr_freq, wr_link, wr_wdc, wr_wdd, rd_link, freq_ok, cmp_ok;
  logic [16:0] tick_top;

  assign wr_node = cfg_wr && cfg_addr == ncw_pkg::REG_NODE_CFG && !lock_q;
  assign wr_freq = cfg_wr && cfg_addr == ncw_pkg::REG_OSC_FREQ;
  assign wr_link = cfg_wr && cfg_addr == ncw_pkg::REG_LINK_CTRL && !lock_q;
  assign wr_wdc  = cfg_wr && cfg_addr == ncw_pkg::REG_WDOG_CTRL;
  assign wr_wdd  = cfg_wr && cfg_addr == ncw_pkg::REG_WDOG_DIS;
  assign rd_link = cfg_rd && cfg_addr == ncw_pkg::REG_LINK_CTRL;
  assign freq_ok = cfg_wdata[6:0] >= ncw_pkg::FREQ_MIN && cfg_wdata[6:0] <= ncw_pkg::FREQ_MAX
                   && cfg_wdata[31:7] == 25'h0000000;
  assign cmp_ok  = cfg_wdata[31:16] == ~cfg_wdata[15:0];

  // node configuration: lock is sticky until reset
  always_ff @(posedge clk) begin
    if (!nrst) begin
      lock_q <= 1'b0;
      hdr_q  <= 1'b0;
    end else if (wr_node) begin
      lock_q <= cfg_wdata[ncw_pkg::NODE_LOCK_BIT];
      hdr_q  <= cfg_wdata[ncw_pkg::NODE_HDR_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      freq_q <= ncw_pkg::FREQ_RST;
    end else if (wr_freq && freq_ok) begin
      freq_q <= cfg_wdata[6:0];
    end
  end

  // link spacing fields and self-clearing commands
  always_ff @(posedge clk) begin
    if (!nrst) begin
      trans_gap_q <= ncw_pkg::LNK_GAP_RST;
      tok_gap_q   <= ncw_pkg::LNK_GAP_RST;
      init_req_q  <= 1'b0;
      rx_resync_q <= 1'b0;
    end else begin
      rx_resync_q <= wr_link && cfg_wdata[ncw_pkg::LNK_RXRST_BIT];
      if (wr_link) begin
        trans_gap_q <= cfg_wdata[ncw_pkg::LNK_TRANS_LSB +: ncw_pkg::LNK_GAP_W];
        tok_gap_q   <= cfg_wdata[ncw_pkg::LNK_TOK_LSB +: ncw_pkg::LNK_GAP_W];
      end
      if (wr_link && cfg_wdata[ncw_pkg::LNK_INIT_BIT]) begin
        init_req_q <= 1'b1;
      end else if (tok_start) begin
        init_req_q <= 1'b0;
      end
    end
  end

  // greeting leaves once both spacings have elapsed since the last token
  assign tok_start = init_req_q && !tok_busy && !trans_busy;
  ncw_gap_timer u_tok_gap (
    .clk   (clk),
    .nrst  (nrst),
    .start (tok_start),
    .gap   (tok_gap_q),
    .busy  (tok_busy)
  );
  ncw_gap_timer u_trans_gap (
    .clk   (clk),
    .nrst  (nrst),
    .start (tok_start),
    .gap   (trans_gap_q),
    .busy  (trans_busy)
  );

  always_ff @(posedge clk) begin
    if (!nrst) begin
      link.dev_tok     <= 9'h000;
      link.dev_tok_vld <= 1'b0;
    end else begin
      link.dev_tok     <= ncw_pkg::TOK_GREETING;
      link.dev_tok_vld <= tok_start;
    end
  end

  // credit and error status; set beats clear on error
  always_ff @(posedge clk) begin
    if (!nrst) begin
      err_q    <= 1'b0;
      issued_q <= 1'b0;
      have_q   <= 1'b0;
    end else begin
      if (link.rem_bad || link.rem_ovf) begin
        err_q <= 1'b1;
      end else if (rd_link) begin
        err_q <= 1'b0;
      end
      if (tok_start) begin
        have_q <= 1'b0;
      end else if (link.rem_tok_vld && link.rem_tok == ncw_pkg::TOK_CREDIT) begin
        have_q <= 1'b1;
      end
      if (link.rem_tok_vld && link.rem_tok == ncw_pkg::TOK_GREETING) begin
        issued_q <= 1'b1;
      end else if (rx_resync_q) begin
        issued_q <= 1'b0;
      end
    end
  end

  // 1 kHz tick from programmed MHz
  assign tick_top = 17'(freq_q * ncw_pkg::TICK_PER_MHZ) - 17'h00001;
  always_ff @(posedge clk) begin
    if (!nrst) begin
      tick_div_q   <= 17'h00000;
      tick_q       <= 1'b0;
      sleep_tick_q <= 1'b0;
    end else begin
      tick_q       <= tick_div_q >= tick_top;
      sleep_tick_q <= tick_div_q >= tick_top && !active_power_state;
      tick_div_q   <= (tick_div_q >= tick_top) ? 17'h00000 : tick_div_q + 17'h00001;
    end
  end

  // watchdog; disable register holds the last written key
  always_ff @(posedge clk) begin
    if (!nrst) begin
      wd_dis_q <= ncw_pkg::WD_DIS_KEY;
      wd_en_q  <= 1'b0;
    end else if (wr_wdd) begin
      wd_dis_q <= cfg_wdata;
      if (cfg_wdata == ncw_pkg::WD_DIS_KEY) begin
        wd_en_q <= 1'b0;
      end else if (cfg_wdata == ncw_pkg::WD_EN_KEY) begin
        wd_en_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      wd_to_q <= ncw_pkg::WD_TIMEOUT_RST;
    end else if (wr_wdc && cmp_ok) begin
      wd_to_q <= cfg_wdata[15:0];
    end
  end

  // count of elapsed ticks; a good timeout write also acts as a kick
  assign wd_restart = wd_kick || (wr_wdc && cmp_ok);
  always_ff @(posedge clk) begin
    if (!nrst) begin
      wd_cnt_q <= 16'h0000;
    end else if (!wd_en_q || wd_restart || tile_reset_q) begin
      wd_cnt_q <= 16'h0000;
    end else if (tick_q && active_power_state) begin
      wd_cnt_q <= wd_cnt_q + 16'h0001;
    end
  end

  // processor reset held for a frequency-scaled delay after expiry
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rst_dly_q    <= 12'h000;
      tile_reset_q <= 1'b0;
    end else if (wd_en_q && !tile_reset_q && wd_cnt_q >= wd_to_q) begin
      tile_reset_q <= 1'b1;
      rst_dly_q    <= 12'(freq_q * ncw_pkg::RST_DELAY_PER_MHZ);
    end else if (rst_dly_q != 12'h000) begin
      rst_dly_q <= rst_dly_q - 12'h001;
    end else begin
      tile_reset_q <= 1'b0;
    end
  end

  // read data and answers
  always_ff @(posedge clk) begin
    if (!nrst) begin
      cfg_rdata_q <= 32'h00000000;
      cfg_ans_q   <= ncw_pkg::NCW_ANS_NONE;
    end else begin
      cfg_ans_q <= ncw_pkg::NCW_ANS_NONE;
      if (cfg_wr) begin
        if (cfg_addr == ncw_pkg::REG_OSC_FREQ) begin
          cfg_ans_q <= freq_ok ? ncw_pkg::NCW_ANS_ACK : ncw_pkg::NCW_ANS_NACK;
        end else if (cfg_addr == ncw_pkg::REG_WDOG_CTRL) begin
          cfg_ans_q <= cmp_ok ? ncw_pkg::NCW_ANS_ACK : ncw_pkg::NCW_ANS_NACK;
        end else if (cfg_addr == ncw_pkg::REG_WDOG_DIS || cfg_addr == ncw_pkg::REG_NODE_CFG
                     || cfg_addr == ncw_pkg::REG_LINK_CTRL) begin
          cfg_ans_q <= ncw_pkg::NCW_ANS_ACK;
        end else begin
          cfg_ans_q <= ncw_pkg::NCW_ANS_NACK;
        end
      end else if (cfg_rd) begin
        cfg_ans_q   <= ncw_pkg::NCW_ANS_ACK;
        cfg_rdata_q <= 32'h00000000;
        if (cfg_addr == ncw_pkg::REG_NODE_CFG) begin
          cfg_rdata_q <= {lock_q, 30'h00000000, hdr_q};
        end else if (cfg_addr == ncw_pkg::REG_OSC_FREQ) begin
          cfg_rdata_q <= {25'h0000000, freq_q};
        end else if (cfg_addr == ncw_pkg::REG_LINK_CTRL) begin
          cfg_rdata_q <= {4'h0, err_q, issued_q, have_q, 3'h0,
                          trans_gap_q, tok_gap_q};
        end else if (cfg_addr == ncw_pkg::REG_WDOG_CTRL) begin
          cfg_rdata_q <= {wd_cnt_q, wd_to_q};
        end else if (cfg_addr == ncw_pkg::REG_WDOG_DIS) begin
          cfg_rdata_q <= wd_dis_q;
        end else begin
          cfg_ans_q <= ncw_pkg::NCW_ANS_NACK;
        end
      end
    end
  end
endmodule : ncw_node_regs
`default_nettype wire

/* src/ncw_pkg.sv */
// package: register map, field layout, reset values and timing for node config regs
`default_nettype none
package ncw_pkg;
  // register indices on the configuration bus
  localparam logic [7:0]  REG_NODE_CFG   = 8'h04;
  localparam logic [7:0]  REG_OSC_FREQ   = 8'h51;
  localparam logic [7:0]  REG_LINK_CTRL  = 8'h80;
  localparam logic [7:0]  REG_WDOG_CTRL  = 8'hD6;
  localparam logic [7:0]  REG_WDOG_DIS   = 8'hD7;
  // oscillator frequency field
  localparam int          FREQ_W         = 7;
  localparam logic [6:0]  FREQ_RST       = 7'h19;
  localparam logic [6:0]  FREQ_MIN       = 7'h05;
  localparam logic [6:0]  FREQ_MAX       = 7'h64;
  // node configuration
  localparam int          NODE_LOCK_BIT  = 31;
  localparam int          NODE_HDR_BIT   = 0;
  // link control and status fields
  localparam int          LNK_ERR_BIT    = 27;
  localparam int          LNK_ISSUED_BIT = 26;
  localparam int          LNK_HAVE_BIT   = 25;
  localparam int          LNK_INIT_BIT   = 24;
  localparam int          LNK_RXRST_BIT  = 23;
  localparam int          LNK_TRANS_LSB  = 11;
  localparam int          LNK_TOK_LSB    = 0;
  localparam int          LNK_GAP_W      = 11;
  localparam logic [10:0] LNK_GAP_RST    = 11'h001;
  // watchdog
  localparam int          WD_W           = 16;
  localparam logic [15:0] WD_TIMEOUT_RST = 16'h03E8;
  localparam logic [31:0] WD_DIS_KEY     = 32'h0D15AB1E;
  localparam logic [31:0] WD_EN_KEY      = 32'h00000000;
  localparam int          TICK_PER_MHZ   = 1000;
  localparam int          TICK_CNT_W     = 17;
  // processor reset delay: cycles per MHz of programmed frequency
  localparam int          RST_DELAY_PER_MHZ = 16;
  localparam int          RST_DELAY_W    = 12;
  // link tokens
  localparam int          TOK_W          = 9;
  localparam logic [8:0]  TOK_GREETING   = 9'h1E0;
  localparam logic [8:0]  TOK_CREDIT     = 9'h1E1;
  // configuration access answers
  typedef enum logic [1:0] {
    NCW_ANS_NONE = 2'b00,
    NCW_ANS_ACK  = 2'b01,
    NCW_ANS_NACK = 2'b10
  } ncw_ans_t;
endpackage : ncw_pkg
`default_nettype wire

/* src/ncw_link_if.sv */
// interface: token link between this node and the remote link endpoint
`default_nettype none
interface ncw_link_if;
  logic [8:0] dev_tok;
  logic       dev_tok_vld;
  logic [8:0] rem_tok;
  logic       rem_tok_vld;
  logic       rem_bad;
  logic       rem_ovf;
  modport dev (output dev_tok, output dev_tok_vld,
               input rem_tok, input rem_tok_vld, input rem_bad, input rem_ovf);
  modport rem (input dev_tok, input dev_tok_vld,
               output rem_tok, output rem_tok_vld, output rem_bad, output rem_ovf);
endinterface : ncw_link_if
`default_nettype wire

/* src/ncw_gap_timer.sv */
// module: programmable cycle spacer, reloads on start and holds busy until the gap has passed
`default_nettype none
module ncw_gap_timer (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        nrst,
  // control
  input  wire logic        start,
  input  wire logic [10:0] gap,
  // status
  output logic             busy
);
  logic [10:0] cnt_q;
  always_ff @(posedge clk) begin
    if (!nrst) begin
      cnt_q <= 11'h000;
    end else if (start) begin
      cnt_q <= gap;
    end else if (cnt_q != 11'h000) begin
      cnt_q <= cnt_q - 11'h001;
    end
  end
  assign busy = (cnt_q != 11'h000);
endmodule : ncw_gap_timer
`default_nettype wire

/* src/ncw_remote_end.sv */
// module: remote link endpoint that answers a greeting token with credit
`default_nettype none
module ncw_remote_end (
  // clock and reset
  input  wire logic clk,
  input  wire logic nrst,
  // link
  ncw_link_if.rem   link,
  // user side
  input  wire logic inject_bad,
  input  wire logic inject_ovf,
  output logic      greeted_q
);
  logic pend_q;
  // answer a greeting with one credit token
  always_ff @(posedge clk) begin
    if (!nrst) begin
      pend_q <= 1'b0;
    end else if (link.dev_tok_vld && link.dev_tok == ncw_pkg::TOK_GREETING) begin
      pend_q <= 1'b1;
    end else if (pend_q) begin
      pend_q <= 1'b0;
    end
  end
  always_ff @(posedge clk) begin
    if (!nrst) begin
      link.rem_tok     <= 9'h000;
      link.rem_tok_vld <= 1'b0;
      link.rem_bad     <= 1'b0;
      link.rem_ovf     <= 1'b0;
      greeted_q        <= 1'b0;
    end else begin
      link.rem_tok     <= ncw_pkg::TOK_CREDIT;
      link.rem_tok_vld <= pend_q;
      link.rem_bad     <= inject_bad;
      link.rem_ovf     <= inject_ovf;
      if (pend_q) begin
        greeted_q <= 1'b1;
      end
    end
  end
endmodule : ncw_remote_end
`default_nettype wire

/* verification/ncw_link_sva.sv */
// checker: token exchange on the link between the two ends
`default_nettype none
module ncw_link_sva (
  // clock and reset
  input wire logic       clk,
  input wire logic       nrst,
  // device to remote
  input wire logic [8:0] dev_tok,
  input wire logic       dev_tok_vld,
  // remote to device
  input wire logic [8:0] rem_tok,
  input wire logic       rem_tok_vld,
  input wire logic       rem_bad,
  input wire logic       rem_ovf
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  a_greet_code: assert property (dev_tok_vld |-> dev_tok == ncw_pkg::TOK_GREETING)
    else $error("device token is not a greeting");
  a_greet_answered: assert property (dev_tok_vld |-> ##2 rem_tok_vld)
    else $error("greeting not answered in two cycles");
  a_answer_gap: assert property (dev_tok_vld |=> !rem_tok_vld ##1 rem_tok_vld)
    else $error("credit answer came at the wrong cycle");
  a_credit_code: assert property (rem_tok_vld |-> rem_tok == ncw_pkg::TOK_CREDIT)
    else $error("remote token is not a credit");
  a_credit_cause: assert property (rem_tok_vld |-> $past(dev_tok_vld, 2))
    else $error("credit sent without a greeting");
  a_credit_past: assert property (rem_tok_vld |-> $past(dev_tok, 2) == ncw_pkg::TOK_GREETING)
    else $error("credit not preceded by a greeting token");
  // spacing is at least two cycles even with both gaps at their reset value of 1
  a_dev_pulse: assert property (dev_tok_vld |=> !dev_tok_vld)
    else $error("device tokens closer than the gap");
  a_rem_pulse: assert property (rem_tok_vld |=> !rem_tok_vld)
    else $error("remote valid held for more than a cycle");
  c_err_seen: cover property (rem_bad || rem_ovf);
endmodule : ncw_link_sva
`default_nettype wire

/* verification/node_config_link_watchdog_regs_bench.sv */
// bench: register access, link start-up and watchdog checks for the node config regs
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin bad_count++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, (g), (e)); end end
module node_config_link_watchdog_regs_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic                clk        = 1'b0;
  logic                nrst       = 1'b0;
  logic                cfg_wr     = 1'b0;
  logic                cfg_rd     = 1'b0;
  logic [7:0]          cfg_addr   = 8'h00;
  logic [31:0]         cfg_wdata  = 32'h0;
  logic                active     = 1'b0;
  logic                wd_kick    = 1'b0;
  logic                inject_bad = 1'b0;
  logic                inject_ovf = 1'b0;
  logic [31:0]         cfg_rdata_q;
  ncw_pkg::ncw_ans_t   cfg_ans_q;
  logic                tile_reset_q;
  logic                rx_resync_q;
  logic                sleep_tick_q;
  logic                greeted_q;
  logic [8:0]          last_tok   = 9'h000;
  int                  bad_count  = 0;
  int                  n_compared = 0;
  int                  greet_n    = 0;
  int                  resync_n   = 0;
  int                  sleep_n    = 0;
  int                  n;
  int                  s0;
  logic [6:0]          fv[4]      = '{7'h04, 7'h05, 7'h65, 7'h64};
  logic [6:0]          fr[4]      = '{7'h19, 7'h05, 7'h05, 7'h64};
  ncw_link_if link_i ();
  ncw_node_regs u_ncw_node_regs (.clk(clk), .nrst(nrst), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
    .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata_q(cfg_rdata_q),
    .cfg_ans_q(cfg_ans_q), .active_power_state(active), .wd_kick(wd_kick), .link(link_i),
    .tile_reset_q(tile_reset_q), .rx_resync_q(rx_resync_q), .sleep_tick_q(sleep_tick_q));
  ncw_remote_end u_ncw_remote_end (.clk(clk), .nrst(nrst), .link(link_i),
    .inject_bad(inject_bad), .inject_ovf(inject_ovf), .greeted_q(greeted_q));
  ncw_link_sva u_ncw_link_sva (.clk(clk), .nrst(nrst), .dev_tok(link_i.dev_tok),
    .dev_tok_vld(link_i.dev_tok_vld), .rem_tok(link_i.rem_tok),
    .rem_tok_vld(link_i.rem_tok_vld), .rem_bad(link_i.rem_bad), .rem_ovf(link_i.rem_ovf));
  always #5 clk = ~clk;
  // counts are kept here so pulses shorter than a task call are not missed
  always @(posedge clk) begin
    if (link_i.dev_tok_vld === 1'b1) begin
      greet_n++;
      last_tok = link_i.dev_tok;
    end
    if (rx_resync_q === 1'b1) resync_n++;
    if (sleep_tick_q === 1'b1) sleep_n++;
  end
  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : test_done
  // one access; the answer is awaited for a few cycles, then compared
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d, input logic ok);
    int i;
    @(posedge clk);
    cfg_wr    <= w;
    cfg_rd    <= ~w;
    cfg_addr  <= a;
    cfg_wdata <= d;
    @(posedge clk);
    cfg_wr <= 1'b0;
    cfg_rd <= 1'b0;
    #1;
    for (i = 0; i < 3 && cfg_ans_q === ncw_pkg::NCW_ANS_NONE; i++) begin
      @(posedge clk);
      #1;
    end
    `CHK(cfg_ans_q, ok ? ncw_pkg::NCW_ANS_ACK : ncw_pkg::NCW_ANS_NACK)
  endtask : acc
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
    acc(1'b0, a, 32'h0, 1'b1);
    `CHK(cfg_rdata_q & m, x)
  endtask : rd
  task automatic wait_tile(input int lim, output int k);
    k = 0;
    while (k < lim && tile_reset_q !== 1'b1) begin
      @(posedge clk);
      #1;
      k++;
    end
  endtask : wait_tile
  initial begin
    #800us;
    bad_count++;
    test_done();
  end
  initial begin
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    rd(8'h51, 32'h7F, 32'h19);
    rd(8'hD6, 32'hFFFFFFFF, 32'h03E8);
    rd(8'hD7, 32'hFFFFFFFF, 32'h0D15AB1E);
    rd(8'h80, 32'h0E3FFFFF, 32'h0801);
    for (int k = 0; k < 4; k++) begin
      acc(1'b1, 8'h51, {25'h0, fv[k]}, k[0]);
      rd(8'h51, 32'h7F, {25'h0, fr[k]});
    end
    acc(1'b1, 8'h10, 32'h0, 1'b0);
    acc(1'b1, 8'hD6, 32'hFFFC0003, 1'b1);
    acc(1'b1, 8'hD6, 32'h00000004, 1'b0);
    rd(8'hD6, 32'hFFFF, 32'h3);
    acc(1'b1, 8'h80, 32'h00002807, 1'b1);
    rd(8'h80, 32'h003FFFFF, 32'h2807);
    acc(1'b1, 8'h80, 32'h01002807, 1'b1);
    for (int k = 0; k < 20 && greeted_q !== 1'b1; k++) @(posedge clk);
    #1;
    `CHK(greeted_q, 1'b1)
    `CHK(greet_n, 1)
    `CHK(last_tok, ncw_pkg::TOK_GREETING)
    rd(8'h80, 32'h0F000000, 32'h02000000);
    for (int k = 0; k < 2; k++) begin
      @(posedge clk);
      inject_bad <= (k == 0);
      inject_ovf <= (k == 1);
      @(posedge clk);
      inject_bad <= 1'b0;
      inject_ovf <= 1'b0;
      repeat (3) @(posedge clk);
      rd(8'h80, 32'h08000000, 32'h08000000);
      rd(8'h80, 32'h08000000, 32'h0);
    end
    acc(1'b1, 8'h80, 32'h00802807, 1'b1);
    repeat (3) @(posedge clk);
    `CHK(resync_n, 1)
    rd(8'h80, 32'h04800000, 32'h0);
    // slowest legal frequency keeps the watchdog tick short enough to simulate
    acc(1'b1, 8'h51, 32'h5, 1'b1);
    acc(1'b1, 8'hD6, 32'hFFFD0002, 1'b1);
    acc(1'b1, 8'hD7, 32'h0, 1'b1);
    s0 = sleep_n;
    wait_tile(11000, n);
    `CHK(n, 11000)
    `CHK(sleep_n - s0 >= 2, 1'b1)
    rd(8'hD6, 32'hFFFF0000, 32'h0);
    @(posedge clk);
    active <= 1'b1;
    wait_tile(12000, n);
    `CHK(n >= 5000 && n <= 10010, 1'b1)
    n = 0;
    while (tile_reset_q === 1'b1 && n < 200) begin
      @(posedge clk);
      #1;
      n++;
    end
    `CHK(n, 81)
    // kicks closer than one tick apart must keep the tile out of reset
    for (int k = 0; k < 3; k++) begin
      wait_tile(4000, n);
      `CHK(n, 4000)
      @(posedge clk);
      wd_kick <= 1'b1;
      @(posedge clk);
      wd_kick <= 1'b0;
    end
    acc(1'b1, 8'hD7, 32'h0D15AB1E, 1'b1);
    wait_tile(11000, n);
    `CHK(n, 11000)
    acc(1'b1, 8'h04, 32'h80000000, 1'b1);
    acc(1'b1, 8'h80, 32'h00000801, 1'b1);
    rd(8'h80, 32'h003FFFFF, 32'h2807);
    test_done();
  end
endmodule : node_config_link_watchdog_regs_bench
`default_nettype wire
